// ===== verilog/eep_serial_mem.sv
// Two-wire serial memory slave with self-timed write cycle
//
// Overview of operation
// - Write cycle starts at stop after write
// - No acknowledge while write cycle runs
// - Acknowledge address once write cycle done
// - Current, random and sequential reads supported
// - Address counter holds last access plus one, wrapping in the page after a write
// - Current read: ack, then eight data bits
// - Random read sends word at loaded address
// - Each master ack fetches next word
// - Read counter wraps all eight bits
// - Match type code and chip select pins
// - On nack release line, await stop
// - Byte after write address loads counter
// - Ignore all traffic during write cycle
`timescale 1ns/1ps
`default_nettype none

module eep_serial_mem #(
  parameter int unsigned WR_CYCLES = eep_pkg::WR_CYCLES_DEF,
  parameter logic [3:0] DEV_TYPE = eep_pkg::DEV_TYPE_DEF
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Two-wire link
  input wire logic scl,
  input wire logic sda_in,
  output var eep_pkg::eep_drive_t sda_drive,
  // Device pins
  input wire logic chip_select_pin_0,
  input wire logic chip_select_pin_1,
  input wire logic chip_select_pin_2,
  input wire logic write_inhibit_input,
  // Status
  output logic write_busy
);
  import eep_pkg::*;

  localparam int unsigned TW = $clog2(WR_CYCLES + 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [DW-1:0] mem_q [MEM_WORDS];
  logic [DW-1:0] buf_q [BUF_DEPTH];
  eep_state_t st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [DW-1:0] sh_q, sh_d;
  eep_drive_t drv_q, drv_d;
  logic [AW-1:0] addr_q, addr_d;
  logic wpend_q, wpend_d;
  logic [AW-1:0] fetch_q, fetch_d;
  logic [1:0] bcnt_q, bcnt_d;
  logic wp_q, wp_d, rp_q, rp_d;
  logic samp_q;
  logic [4:0] pin_s1_q, pin_s2_q;
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic wp_s1_q, wp_s2_q;
  logic busy_q, busy_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic frst_q, frst_d;
  logic link_rst;
  logic [DW-1:0] rx_byte, pop_data;
  eep_saddr_t sa;
  logic [2:0] cs_s;
  logic inhibit_s, busy_s;
  logic mem_we, flush, start;
  logic push_vld, push_rdy, pop_vld, pop_rdy, push, pop;
  logic stop_ev;

  // ----------------------------------------------------------------
  // Link domain: sampling and pin synchronisers
  // ----------------------------------------------------------------
  // Frame state is also cleared by the core once a stop is seen,
  // because the link clock stands still after the stop
  assign link_rst = sys_rst | frst_q;

  // Data bits are valid at the rising edge of the link clock
  always_ff @(posedge scl or posedge sys_rst) begin
    if (sys_rst) begin
      samp_q <= 1'b1;
    end else begin
      samp_q <= sda_in;
    end
  end

  // Straps, inhibit and busy settle within the address byte
  always_ff @(negedge scl or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {write_inhibit_input, chip_select_pin_2,
                   chip_select_pin_1, chip_select_pin_0, busy_q};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign inhibit_s = pin_s2_q[4];
  assign cs_s = pin_s2_q[3:1];
  assign busy_s = pin_s2_q[0];

  // ----------------------------------------------------------------
  // Link domain: byte engine
  // ----------------------------------------------------------------
  assign rx_byte = {sh_q[DW-2:0], samp_q};
  assign sa = eep_saddr_t'(rx_byte);
  // A falling data line under a high clock shows here as a mismatch
  // between the rising-edge sample and the level at the falling edge
  assign start = (st_q == ST_IDLE) || (samp_q && !sda_in);

  // Next state of the serial engine, one decision per falling edge
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    drv_d = drv_q;
    addr_d = addr_q;
    wpend_d = wpend_q;
    mem_we = 1'b0;
    pop_rdy = 1'b0;
    flush = 1'b0;
    if (start) begin
      // Abandon any transfer; the address counter is kept
      st_d = ST_ADDR;
      cnt_d = '0;
      drv_d.oe = 1'b0;
      flush = 1'b1;
    end else begin
      unique case (st_q)
        ST_ADDR, ST_WORD, ST_DATA: begin
          if (cnt_q < LAST_BIT) begin
            sh_d = rx_byte;
            cnt_d = cnt_q + 1'b1;
          end else if (cnt_q == LAST_BIT) begin
            cnt_d = ACK_SLOT;
            if (st_q == ST_ADDR) begin
              // Busy devices stay silent, which is what polling sees
              if (sa.dtype == DEV_TYPE && sa.sel == cs_s
                  && !busy_s) begin
                drv_d.oe = 1'b1;
                st_d = sa.rd ? ST_TX : ST_WORD;
              end else begin
                st_d = ST_WAIT;
              end
            end else if (st_q == ST_WORD) begin
              addr_d = rx_byte;
              drv_d.oe = 1'b1;
              st_d = ST_DATA;
              flush = 1'b1;
            end else begin
              // Page write wraps within the low address bits
              drv_d.oe = 1'b1;
              flush = 1'b1;
              if (!inhibit_s) begin
                mem_we = 1'b1;
                wpend_d = 1'b1;
              end
              addr_d = {addr_q[AW-1:PAGE_BITS],
                        addr_q[PAGE_BITS-1:0] + 1'b1};
            end
          end else begin
            // End of the acknowledge clock
            drv_d.oe = 1'b0;
            cnt_d = '0;
          end
        end
        ST_TX: begin
          if (cnt_q < LAST_BIT) begin
            drv_d.oe = ~sh_q[DW-1];
            sh_d = {sh_q[DW-2:0], 1'b1};
            cnt_d = cnt_q + 1'b1;
          end else if (cnt_q == LAST_BIT) begin
            // Release for the receiver's acknowledge
            drv_d.oe = 1'b0;
            cnt_d = ACK_SLOT;
          end else if (!samp_q) begin
            // Own address ack or master ack: send the next word
            pop_rdy = 1'b1;
            sh_d = {pop_data[DW-2:0], 1'b1};
            drv_d.oe = ~pop_data[DW-1];
            cnt_d = '0;
            if (pop_vld) begin
              addr_d = addr_q + 1'b1;
            end
          end else begin
            // Missing ack ends the read until the next frame
            drv_d.oe = 1'b0;
            st_d = ST_WAIT;
          end
        end
        ST_WAIT: begin
          drv_d.oe = 1'b0;
        end
        default: begin
          drv_d.oe = 1'b0;
          st_d = ST_WAIT;
        end
      endcase
    end
  end

  // Frame state, cleared by reset or by a seen stop
  always_ff @(negedge scl or posedge link_rst) begin
    if (link_rst) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      drv_q <= '0;
      wpend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      drv_q <= drv_d;
      wpend_q <= wpend_d;
    end
  end

  // Address counter survives stops and restarts
  always_ff @(negedge scl or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q <= ADDR_RST;
    end else begin
      addr_q <= addr_d;
    end
  end

  // Storage array; contents hold no reset value
  always_ff @(negedge scl) begin
    if (mem_we) begin
      mem_q[addr_q] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: two-entry staging buffer
  // ----------------------------------------------------------------
  // Prefetch keeps a word ready at each ack; a full buffer stalls it
  assign push_vld = !flush;
  assign push_rdy = (bcnt_q < 2'(BUF_DEPTH));
  assign pop_vld = (bcnt_q != 2'd0);
  assign pop_data = pop_vld ? buf_q[rp_q] : IDLE_BYTE;
  assign push = push_vld && push_rdy;
  assign pop = pop_vld && pop_rdy;

  // Pointer and fill level updates
  always_comb begin
    fetch_d = fetch_q;
    wp_d = wp_q;
    rp_d = rp_q;
    bcnt_d = bcnt_q;
    if (flush) begin
      // Staged words may be stale after a new address or a write
      fetch_d = addr_d;
      wp_d = 1'b0;
      rp_d = 1'b0;
      bcnt_d = 2'd0;
    end else begin
      if (push) begin
        fetch_d = fetch_q + 1'b1;
        wp_d = ~wp_q;
      end
      if (pop) begin
        rp_d = ~rp_q;
      end
      bcnt_d = bcnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(negedge scl or posedge link_rst) begin
    if (link_rst) begin
      fetch_q <= ADDR_RST;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      bcnt_q <= 2'd0;
    end else begin
      fetch_q <= fetch_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
      bcnt_q <= bcnt_d;
    end
  end

  // Buffer entries
  always_ff @(negedge scl) begin
    if (push) begin
      buf_q[wp_q] <= mem_q[fetch_q];
    end
  end

  // ----------------------------------------------------------------
  // Core domain: stop detection and write cycle timer
  // ----------------------------------------------------------------
  // Edges are judged on second and third stages
  assign stop_ev = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;

  // Busy timer and frame clear pulse
  always_comb begin
    busy_d = busy_q;
    tmr_d = tmr_q;
    frst_d = stop_ev;
    if (busy_q) begin
      tmr_d = tmr_q - 1'b1;
      if (tmr_q == TW'(1)) begin
        busy_d = 1'b0;
      end
    end else if (stop_ev && wp_s2_q) begin
      busy_d = 1'b1;
      tmr_d = TW'(WR_CYCLES);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      wp_s1_q <= 1'b0;
      wp_s2_q <= 1'b0;
      busy_q <= 1'b0;
      tmr_q <= '0;
      frst_q <= 1'b0;
    end else begin
      scl_s1_q <= scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      wp_s1_q <= wpend_q;
      wp_s2_q <= wp_s1_q;
      busy_q <= busy_d;
      tmr_q <= tmr_d;
      frst_q <= frst_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_drive = drv_q;
  assign write_busy = busy_q;

endmodule

`default_nettype wire

// ===== verilog/eep_pkg.sv
// Constants and types shared by the serial memory slave
package eep_pkg;

  // ----------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------
  localparam int unsigned MEM_WORDS = 256;
  localparam int unsigned DW = 8;
  localparam int unsigned AW = 8;
  localparam logic [AW-1:0] ADDR_RST = 8'h00;
  // Page writes wrap inside this many low address bits
  localparam int unsigned PAGE_BITS = 2;

  // ----------------------------------------------------------------
  // Slave address and byte framing
  // ----------------------------------------------------------------
  // Device type code; the value is arbitrary
  localparam logic [3:0] DEV_TYPE_DEF = 4'h6;
  // Bit slots 0..7 carry data, slot 8 is the acknowledge clock
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // Sent when no word is staged; reads as a released line
  localparam logic [DW-1:0] IDLE_BYTE = 8'hff;

  // ----------------------------------------------------------------
  // Staging buffer and write cycle timing
  // ----------------------------------------------------------------
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned WR_TIME_MS = 10;
  localparam int unsigned CORE_CLK_HZ = 40_000_000;
  // Longest time, so the count rounds down
  localparam int unsigned WR_CYCLES_DEF =
    WR_TIME_MS * (CORE_CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_WORD = 6'b000100,
    ST_DATA = 6'b001000,
    ST_TX   = 6'b010000,
    ST_WAIT = 6'b100000
  } eep_state_t;

  // Open-drain data pin drive
  typedef struct packed {
    logic out;
    logic oe;
  } eep_drive_t;

  // Slave address byte layout, msb first
  typedef struct packed {
    logic [3:0] dtype;
    logic [2:0] sel;
    logic rd;
  } eep_saddr_t;

endpackage

// ===== testbench/eep_serial_mem_properties.sv
// Port checker for the serial memory slave
`timescale 1ns/1ps
`default_nettype none

module eep_serial_mem_properties #(
  parameter int unsigned WR_CYCLES = 50
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Link and pins
  input wire logic scl,
  input wire logic sda_in,
  input wire eep_pkg::eep_drive_t sda_drive,
  input wire logic chip_select_pin_0,
  input wire logic chip_select_pin_1,
  input wire logic chip_select_pin_2,
  input wire logic write_inhibit_input,
  input wire logic write_busy
);
  import eep_pkg::*;
  int unsigned busy_cnt_q;
  logic [3:0] stop_age_q;
  logic sda_prev_q;

  // Busy length and time since the last stop seen on the wire
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_q <= 32'd0;
      stop_age_q <= 4'hf;
      sda_prev_q <= 1'b1;
    end else begin
      busy_cnt_q <= write_busy ? busy_cnt_q + 32'd1 : 32'd0;
      sda_prev_q <= sda_in;
      if (scl && sda_in && !sda_prev_q) stop_age_q <= 4'h0;
      else if (stop_age_q != 4'hf) stop_age_q <= stop_age_q + 4'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Stop, then the wire left alone
  sequence s_stop;
    scl && $rose(sda_in);
  endsequence
  sequence s_quiet;
    !sda_drive.oe [*4];
  endsequence

  a_out_low: assert property (!sda_drive.out)
    else $error("data pin driven high");
  a_busy_span: assert property ($fell(write_busy) |-> busy_cnt_q == WR_CYCLES)
    else $error("write cycle length wrong");
  a_busy_bound: assert property (write_busy |-> busy_cnt_q < WR_CYCLES)
    else $error("write cycle overran");
  a_busy_start: assert property ($rose(write_busy) |-> stop_age_q <= 4'ha)
    else $error("write cycle began without stop");
  a_busy_quiet: assert property (write_busy |-> !sda_drive.oe)
    else $error("answer given while busy");
  a_drive_edge: assert property ($changed(sda_drive.oe) |-> !scl)
    else $error("data pin changed while clock high");
  a_stop_release: assert property (s_stop |-> s_quiet)
    else $error("data pin held after stop");
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |-> !sda_drive.oe && !write_busy)
    else $error("outputs active in reset");
endmodule

bind eep_serial_mem eep_serial_mem_properties #(
  .WR_CYCLES(WR_CYCLES)
) u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_in),
  .sda_drive(sda_drive), .chip_select_pin_0(chip_select_pin_0),
  .chip_select_pin_1(chip_select_pin_1),
  .chip_select_pin_2(chip_select_pin_2),
  .write_inhibit_input(write_inhibit_input), .write_busy(write_busy)
);
`default_nettype wire

// ===== testbench/eep_master_model.sv
// Two-wire bus master model driving the link clock and data
`timescale 1ns/1ps
`default_nettype none

module eep_master_model (
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  // Clock stands high and data released between frames
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // One bit: data set mid-low, sampled mid-high
  task automatic clk_bit(input logic b, output logic r);
    #40 sda_oe = !b;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask
  // Start or repeated start from any clock level
  task automatic start();
    #40 sda_oe = 1'b0;
    #40 scl = 1'b1;
    #40 sda_oe = 1'b1;
    #40 scl = 1'b0;
  endtask
  // Stop, then bus-free time so the slave's stop clear completes
  task automatic stop();
    #40 sda_oe = 1'b1;
    #40 scl = 1'b1;
    #40 sda_oe = 1'b0;
    #400;
  endtask
  // Eight bits msb first, then the ninth clock
  task automatic byte9(input logic [7:0] d, input logic b9,
      output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(b9, r);
  endtask
endmodule
`default_nettype wire

// ===== testbench/eep_serial_mem_tb_top.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
`default_nettype none

module eep_serial_mem_tb_top;
  import eep_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } eep_row_t;
  // Ordinary cases: word address and the byte stored there
  eep_row_t rows [4] = '{'{8'hfe, 8'h5a}, '{8'hff, 8'hc3},
    '{8'h00, 8'h3c}, '{8'h41, 8'h96}};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] sel = 3'b101;
  logic inhib = 1'b0;
  logic scl;
  logic m_oe;
  logic sda;
  logic busy;
  eep_drive_t drv;
  int err_total = 0;
  int checks = 0;
  logic [7:0] q;
  logic r;

  always #12.5 core_clk = ~core_clk;
  // Pulled-up wire, low when either party pulls
  assign sda = !(drv.oe || m_oe);

  eep_serial_mem #(.WR_CYCLES(200)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda),
    .sda_drive(drv), .chip_select_pin_0(sel[0]),
    .chip_select_pin_1(sel[1]), .chip_select_pin_2(sel[2]),
    .write_inhibit_input(inhib), .write_busy(busy));
  eep_master_model u_mst (.scl(scl), .sda_oe(m_oe), .sda(sda));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
      input string what);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] sa(input logic rd);
    return {DEV_TYPE_DEF, 3'b101, rd};
  endfunction
  // Dummy write that loads the counter
  task automatic set_addr(input logic [7:0] a);
    u_mst.start();
    u_mst.byte9(sa(1'b0), 1'b1, q, r);
    check({7'h0, r}, 8'h00, "addr ack");
    u_mst.byte9(a, 1'b1, q, r);
    check({7'h0, r}, 8'h00, "word ack");
  endtask
  // Read from the counter, acking all words but the last
  task automatic rd_words(input logic [7:0] exp [$]);
    u_mst.start();
    u_mst.byte9(sa(1'b1), 1'b1, q, r);
    check({7'h0, r}, 8'h00, "read ack");
    foreach (exp[i]) begin
      u_mst.byte9(8'hff, i == exp.size() - 1, q, r);
      check(q, exp[i], "read data");
    end
    u_mst.stop();
  endtask
  // Poll until acked; a part still writing must refuse first
  task automatic poll();
    int naks;
    naks = 0;
    r = 1'b1;
    while (r && naks < 20) begin
      u_mst.start();
      u_mst.byte9(sa(1'b0), 1'b1, q, r);
      u_mst.stop();
      naks += r;
    end
    check({7'h0, r}, 8'h00, "poll ack");
    check({7'h0, naks != 0}, 8'h01, "poll refused");
  endtask
  task automatic wr(input eep_row_t w);
    set_addr(w.addr);
    u_mst.byte9(w.data, 1'b1, q, r);
    u_mst.stop();
    check({7'h0, busy}, 8'h01, "busy");
    poll();
  endtask
  task automatic final_report();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Whole run is near 133 us; the limit leaves wide margin
  initial begin
    #2_000_000;
    err_total++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({6'h0, drv.oe, busy}, 8'h00, "reset outputs");
    foreach (rows[i]) begin
      wr(rows[i]);
      set_addr(rows[i].addr);
      rd_words('{rows[i].data});
    end
    wr(eep_row_t'{8'h40, 8'ha5});
    rd_words('{8'h96});
    set_addr(8'hfe);
    rd_words('{8'h5a, 8'hc3, 8'h3c});
    // Foreign selects, then a foreign type code
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      sel <= i < 3 ? 3'b101 ^ (3'b001 << i) : 3'b101;
      @(posedge core_clk);
      u_mst.start();
      u_mst.byte9(i == 3 ? sa(1'b1) ^ 8'h80 : sa(1'b1), 1'b1, q, r);
      u_mst.stop();
      check({7'h0, r}, 8'h01, "foreign address");
    end
    // Start inside a data byte abandons it
    set_addr(8'h00);
    repeat (4) u_mst.clk_bit(1'b0, r);
    rd_words('{8'h3c});
    check({7'h0, busy}, 8'h00, "aborted write");
    // Inhibited write is acked but neither stored nor timed
    @(posedge core_clk);
    inhib <= 1'b1;
    set_addr(8'h41);
    u_mst.byte9(8'h77, 1'b1, q, r);
    u_mst.stop();
    check({7'h0, r}, 8'h00, "inhibit ack");
    check({7'h0, busy}, 8'h00, "inhibit busy");
    @(posedge core_clk);
    inhib <= 1'b0;
    set_addr(8'h41);
    rd_words('{8'h96});
    // Reset in mid write cycle clears busy and the counter
    set_addr(8'h80);
    u_mst.byte9(8'h11, 1'b1, q, r);
    u_mst.stop();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({7'h0, busy}, 8'h00, "busy after reset");
    rd_words('{8'h3c});
    final_report();
  end
endmodule
`default_nettype wire
